// file: verilog/rx_msg_count_and_elastic_ctrl.sv
// Receive message status and elastic store control register bank.
//
// Contract
// [R1] Buffer pointer names the buffer holding the newest received message.
// [R2] Bit-oriented mode: count sets repetitions needed before end of transfer.
// [R3] Bit-oriented mode with zero count: receive forever, never end transfer.
// [R4] Message-oriented mode: count reports bytes written into the buffer.
// [R5] Reported length includes header bytes and check sequence bytes.
// [R6] Transmit elastic store bit: 0 slip buffer, 1 FIFO.
// [R7] Transmit store only used in fast backplane modes; clock input only (here driven when backplane_fast_i is low).
// [R8] Backplane keeps transmit multiframe timing synchronous with its clock.
// [R9] FIFO latency equals the value in the latency register.
// [R10] Force hold freezes signaling output and array; clear updates again.
// [R11] Hold-on-slip freezes signaling at least one multiframe after slip.
// [R12] Receive store enabled: direction bit 0 output, 1 input for boundary.
// [R13] Receive store bypassed: frame boundary always an output.
// [R14] Mode 00/11 bypass, 01 slip, 10 FIFO; serial clock input when on.
// [R15] Pointer and count update together when a message completes (here only the pointer updates in bit-oriented mode).
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "rx_msg_elastic_defines.svh"
module rx_msg_count_and_elastic_ctrl #(
  parameter int LAT_W = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_link_clk_i,
  input wire logic link_byte_wr_i,
  input wire logic link_msg_end_i,
  input wire logic link_msg_buf_i,
  input wire logic link_bos_rep_i,
  output logic rx_end_of_transfer_o,
  input wire logic backplane_fast_i,
  output logic tx_elastic_active_o,
  output logic tx_elastic_fifo_o,
  output logic tx_serial_clock_oe_n_o,
  output logic rx_serial_clock_oe_n_o,
  output logic [1:0] rx_elastic_mode_o,
  output logic [LAT_W-1:0] fifo_latency_o,
  input wire logic rx_slip_i,
  input wire logic rx_multiframe_i,
  input wire logic [3:0] sig_new_i,
  input wire logic sig_array_we_i,
  output logic [3:0] rx_signaling_out_o,
  output logic sig_array_we_o,
  input wire logic frame_pulse_i,
  input wire logic rx_frame_boundary_i,
  output rx_msg_elastic_pkg::pin_drive_type rx_frame_boundary_o,
  output logic rx_frame_sync_o
);
  import rx_msg_elastic_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic store_on(input logic [1:0] mode);
    store_on = (mode == `RX_MODE_SLIP) || (mode == `RX_MODE_FIFO);
  endfunction

  // --------------------------------------------------------------------
  // Link domain: byte counting and message completion
  // --------------------------------------------------------------------
  // The link reset is a synchronised copy of the system reset.
  logic lrst_meta_q, lrst_q;
  logic [6:0] byte_cnt_q;
  msg_report_type report_q;
  logic msg_tgl_q, rep_tgl_q;
  wire [6:0] byte_cnt_inc = (byte_cnt_q == 7'h7F) ? byte_cnt_q :
    byte_cnt_q + 7'h01;
  // Header and check sequence bytes pass the same write strobe. [R5]
  wire [6:0] final_len = link_byte_wr_i ? byte_cnt_inc : byte_cnt_q;

  always_ff @(posedge rx_link_clk_i) begin
    lrst_meta_q <= sys_rst_i;
    lrst_q <= lrst_meta_q;
  end

  always_ff @(posedge rx_link_clk_i) begin
    if (lrst_q) begin
      byte_cnt_q <= 7'h00;
      report_q <= '0;
      msg_tgl_q <= 1'b0;
      rep_tgl_q <= 1'b0;
    end else begin
      if (link_msg_end_i) begin
        byte_cnt_q <= 7'h00;
        report_q <= '{buf_sel: link_msg_buf_i, length: final_len}; // [R4]
        msg_tgl_q <= ~msg_tgl_q;
      end else if (link_byte_wr_i) begin
        byte_cnt_q <= byte_cnt_inc;
      end
      if (link_bos_rep_i) begin
        rep_tgl_q <= ~rep_tgl_q;
      end
    end
  end

  // --------------------------------------------------------------------
  // Crossing into the system domain
  // --------------------------------------------------------------------
  // The report word is held stable until the next message ends, so it
  // is sampled only on the synchronised toggle edge.
  logic msg_s1_q, msg_s2_q, msg_s3_q;
  logic rep_s1_q, rep_s2_q, rep_s3_q;
  logic fb_s1_q, fb_s2_q;
  wire msg_evt = msg_s2_q ^ msg_s3_q;
  wire rep_evt = rep_s2_q ^ rep_s3_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      msg_s1_q <= 1'b0;
      msg_s2_q <= 1'b0;
      msg_s3_q <= 1'b0;
      rep_s1_q <= 1'b0;
      rep_s2_q <= 1'b0;
      rep_s3_q <= 1'b0;
      fb_s1_q <= 1'b0;
      fb_s2_q <= 1'b0;
    end else begin
      msg_s1_q <= msg_tgl_q;
      msg_s2_q <= msg_s1_q;
      msg_s3_q <= msg_s2_q;
      rep_s1_q <= rep_tgl_q;
      rep_s2_q <= rep_s1_q;
      rep_s3_q <= rep_s2_q;
      fb_s1_q <= rx_frame_boundary_i;
      fb_s2_q <= fb_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] cnt_ptr_q;
  elastic_ctrl_type ectl_q;
  logic [LAT_W-1:0] lat_q;
  logic bos_q;
  wire [9:0] idx = wb_adr_i[11:2];
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr_lane = req && wb_we_i && wb_sel_i[0];
  wire hit_cnt = (idx == `IDX_MSG_COUNT_PTR);
  wire hit_ectl = (idx == `IDX_ELASTIC_CTRL);
  wire hit_lat = (idx == `IDX_FIFO_LATENCY);
  wire hit_dlc = (idx == `IDX_DL_CONTROL);
  wire [7:0] ectl_rd = {ectl_q.tx_fifo_sel, 2'h0, ectl_q.force_hold,
    ectl_q.hold_on_slip, ectl_q.sync_dir, ectl_q.rx_mode};
  wire [31:0] rd_mux = hit_cnt ? {24'h000000, cnt_ptr_q} :
    hit_ectl ? {24'h000000, ectl_rd} :
    hit_lat ? {{(32-LAT_W){1'b0}}, lat_q} :
    hit_dlc ? {31'h00000000, bos_q} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      rdata_q <= req ? rd_mux : rdata_q;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // --------------------------------------------------------------------
  // Message count and pointer register
  // --------------------------------------------------------------------
  wire [7:0] wr_ectl = wb_dat_i[7:0] & `ELASTIC_WR_MASK;
  wire [7:0] ectl_rst = `ELASTIC_CTRL_RST;
  wire [7:0] dlc_rst = `DL_CONTROL_RST;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_ptr_q <= `MSG_COUNT_PTR_RST;
    end else if (msg_evt) begin
      // Pointer always follows the newest buffer; length only in
      // message mode, where the field is a report. [R1] [R15]
      cnt_ptr_q[`MSG_PTR_BIT] <= report_q.buf_sel;
      if (!bos_q) begin
        cnt_ptr_q[6:0] <= report_q.length; // [R4]
      end
    end else if (wr_lane && hit_cnt) begin
      cnt_ptr_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ectl_q <= {ectl_rst[7], ectl_rst[4:0]};
      lat_q <= LAT_W'(`FIFO_LATENCY_RST);
      bos_q <= dlc_rst[`BOS_MODE_BIT];
    end else if (wr_lane) begin
      if (hit_ectl) begin
        ectl_q <= {wr_ectl[7], wr_ectl[4:0]};
      end
      if (hit_lat) begin
        lat_q <= wb_dat_i[LAT_W-1:0];
      end
      if (hit_dlc) begin
        bos_q <= wb_dat_i[`BOS_MODE_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // Bit-oriented repetition counting
  // --------------------------------------------------------------------
  // A write to the count register restarts the count of repetitions.
  logic [6:0] rep_cnt_q;
  logic eot_q, eot_done_q;
  wire [6:0] target = cnt_ptr_q[6:0];
  wire rep_hit = rep_evt && bos_q && (target != 7'h00) && !eot_done_q &&
    (rep_cnt_q + 7'h01 == target);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rep_cnt_q <= 7'h00;
      eot_q <= 1'b0;
      eot_done_q <= 1'b0;
    end else begin
      // A repetition that completes with a rewrite still gets its pulse.
      eot_q <= rep_hit; // [R2] [R3]
      eot_done_q <= !(wr_lane && hit_cnt) && (eot_done_q || rep_hit);
      if (wr_lane && hit_cnt) begin
        rep_cnt_q <= 7'h00;
      end else if (rep_evt && bos_q && !eot_done_q) begin
        rep_cnt_q <= rep_cnt_q + 7'h01;
      end
    end
  end
  assign rx_end_of_transfer_o = eot_q;

  // --------------------------------------------------------------------
  // Elastic store control
  // --------------------------------------------------------------------
  // The transmit store is only live on a fast backplane; its clock is
  // then never driven by this side. Keeping the multiframe timing in
  // step with that clock is the backplane's duty. [R7] [R8]
  assign tx_elastic_active_o = backplane_fast_i;
  assign tx_elastic_fifo_o = backplane_fast_i && ectl_q.tx_fifo_sel; // [R6]
  assign tx_serial_clock_oe_n_o = backplane_fast_i;
  assign rx_elastic_mode_o = ectl_q.rx_mode;
  assign rx_serial_clock_oe_n_o = store_on(ectl_q.rx_mode); // [R14]
  assign fifo_latency_o = lat_q; // [R9]

  pin_drive_type fb_q;
  wire fb_input = store_on(ectl_q.rx_mode) && ectl_q.sync_dir; // [R12] [R13]
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fb_q <= '{o: 1'b0, oe_n: 1'b0};
    end else begin
      fb_q <= '{o: frame_pulse_i, oe_n: fb_input};
    end
  end
  assign rx_frame_boundary_o = fb_q;
  assign rx_frame_sync_o = fb_input ? fb_s2_q : frame_pulse_i;

  // --------------------------------------------------------------------
  // Signaling freeze
  // --------------------------------------------------------------------
  // Waiting for two multiframe marks guarantees a full multiframe even
  // when the slip lands just before a mark.
  freeze_state_type frz_q, frz_d;
  logic [1:0] mf_cnt_q;
  logic [3:0] sig_q;
  wire slip_hold = (frz_q != FRZ_IDLE);
  wire sig_upd = !ectl_q.force_hold && !slip_hold; // [R10]
  wire slip_start = rx_slip_i && ectl_q.hold_on_slip;

  always_comb begin
    frz_d = frz_q;
    case (frz_q)
      FRZ_IDLE: begin
        if (slip_start) begin
          frz_d = FRZ_HOLD;
        end
      end
      FRZ_HOLD: begin
        if (!slip_start && rx_multiframe_i &&
            mf_cnt_q == `MULTIFRAMES_FROZEN - 2'h1) begin
          frz_d = FRZ_IDLE;
        end
      end
      default: begin
        frz_d = FRZ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      frz_q <= FRZ_IDLE;
      mf_cnt_q <= 2'h0;
      sig_q <= 4'h0;
    end else begin
      frz_q <= frz_d; // [R11]
      if (slip_start || !slip_hold) begin
        mf_cnt_q <= 2'h0;
      end else if (rx_multiframe_i) begin
        mf_cnt_q <= mf_cnt_q + 2'h1;
      end
      if (sig_upd) begin
        sig_q <= sig_new_i;
      end
    end
  end
  assign rx_signaling_out_o = sig_q;
  assign sig_array_we_o = sig_array_we_i && sig_upd; // [R10] [R11]

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_ptr_follows;
    @(posedge clk_i) disable iff (sys_rst_i)
      msg_evt |=> cnt_ptr_q[7] == $past(report_q.buf_sel);
  endproperty
  a_ptr_follows: assert property (p_ptr_follows) // [R1]
    else $error("Buffer pointer did not follow the newest message.");

  property p_pair_update;
    @(posedge clk_i) disable iff (sys_rst_i)
      msg_evt && !bos_q |=> cnt_ptr_q == $past(report_q);
  endproperty
  a_pair_update: assert property (p_pair_update) // [R4] [R15]
    else $error("Pointer and length did not update together.");

  property p_eot_on_target;
    @(posedge clk_i) disable iff (sys_rst_i)
      rep_evt && bos_q && target != 7'h00 && !eot_done_q &&
      rep_cnt_q == target - 7'h01
      |=> rx_end_of_transfer_o ##1 !rx_end_of_transfer_o;
  endproperty
  a_eot_on_target: assert property (p_eot_on_target) // [R2]
    else $error("End of transfer missing at repetition target.");

  property p_no_eot_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      bos_q && target == 7'h00 && $stable(target) |=> !rx_end_of_transfer_o;
  endproperty
  a_no_eot_zero: assert property (p_no_eot_zero) // [R3]
    else $error("End of transfer raised with zero count.");

  property p_tx_fifo;
    @(posedge clk_i) disable iff (sys_rst_i)
      (tx_elastic_fifo_o == (backplane_fast_i && ectl_q.tx_fifo_sel)) and
      (backplane_fast_i |-> tx_serial_clock_oe_n_o);
  endproperty
  a_tx_fifo: assert property (p_tx_fifo) // [R6] [R7]
    else $error("Transmit store mode or clock direction wrong.");

  property p_force_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      ectl_q.force_hold |-> !sig_array_we_o ##1 $stable(rx_signaling_out_o);
  endproperty
  a_force_hold: assert property (p_force_hold) // [R10]
    else $error("Signaling changed under forced hold.");

  property p_slip_freeze;
    @(posedge clk_i) disable iff (sys_rst_i)
      slip_start |=> !sig_upd [*3];
  endproperty
  a_slip_freeze: assert property (p_slip_freeze) // [R11]
    else $error("Signaling not frozen after a slip.");

  property p_fb_dir;
    @(posedge clk_i) disable iff (sys_rst_i)
      !store_on(ectl_q.rx_mode) ##1 !store_on(ectl_q.rx_mode)
      |-> !rx_frame_boundary_o.oe_n && !rx_serial_clock_oe_n_o;
  endproperty
  a_fb_dir: assert property (p_fb_dir) // [R13] [R14]
    else $error("Frame boundary not driven while store bypassed.");

  property p_fb_in;
    @(posedge clk_i) disable iff (sys_rst_i)
      store_on(ectl_q.rx_mode) && ectl_q.sync_dir |=>
      rx_frame_boundary_o.oe_n || $changed(ectl_q);
  endproperty
  a_fb_in: assert property (p_fb_in) // [R12]
    else $error("Frame boundary driven while selected as input.");

  c_msg_done: cover property (@(posedge clk_i) msg_evt && !bos_q);
  c_eot: cover property (@(posedge clk_i) rx_end_of_transfer_o);
  c_slip: cover property (@(posedge clk_i) slip_start ##1 slip_hold);
  c_fb_input: cover property (@(posedge clk_i) fb_q.oe_n);
endmodule

// file: common/rx_msg_elastic_defines.svh
// Register indices, field positions, reset values and timing constants.
`ifndef RX_MSG_ELASTIC_DEFINES_SVH
`define RX_MSG_ELASTIC_DEFINES_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_MSG_COUNT_PTR 10'h115
`define IDX_ELASTIC_CTRL 10'h116
`define IDX_FIFO_LATENCY 10'h117
`define IDX_DL_CONTROL 10'h118
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MSG_PTR_BIT 7
`define TX_FIFO_SEL_BIT 7
`define FORCE_HOLD_BIT 4
`define HOLD_SLIP_BIT 3
`define SYNC_DIR_BIT 2
`define BOS_MODE_BIT 0
`define ELASTIC_WR_MASK 8'h9F
// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define MSG_COUNT_PTR_RST 8'h00
`define ELASTIC_CTRL_RST 8'h00
`define FIFO_LATENCY_RST 8'h00
`define DL_CONTROL_RST 8'h00
`define RX_MODE_SLIP 2'h1
`define RX_MODE_FIFO 2'h2
`define MULTIFRAMES_FROZEN 2'h2
`endif

// file: common/rx_msg_elastic_pkg.sv
// Types shared by the receive message and elastic store control block.
package rx_msg_elastic_pkg;
  typedef struct packed {
    logic buf_sel;
    logic [6:0] length;
  } msg_report_type;

  typedef struct packed {
    logic tx_fifo_sel;
    logic force_hold;
    logic hold_on_slip;
    logic sync_dir;
    logic [1:0] rx_mode;
  } elastic_ctrl_type;

  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drive_type;

  typedef enum logic [1:0] {
    FRZ_IDLE,
    FRZ_ARMED,
    FRZ_HOLD
  } freeze_state_type;
endpackage

// file: testbench/dl_link_partner.sv
// Behavioural model of the receive data link that feeds the block.
`timescale 1ns/1ps
module dl_link_partner (
  input wire logic link_clk_i,
  output logic byte_wr_o,
  output logic msg_end_o,
  output logic msg_buf_o,
  output logic bos_rep_o
);
  // ----------------------------------------------------------------------
  // Event generation
  // ----------------------------------------------------------------------
  // Events are launched just after link edges, so their timing stays
  // synchronous with the link clock that carries them.
  initial begin
    byte_wr_o = 1'b0;
    msg_end_o = 1'b0;
    msg_buf_o = 1'b0;
    bos_rep_o = 1'b0;
  end

  // The buffer number is only valid with the end pulse; elsewhere it shows
  // the other value, so a design that samples it early reads the wrong one.
  task automatic send_msg(input logic buf_num, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge link_clk_i);
      byte_wr_o <= 1'b1;
      msg_end_o <= (i == len - 1);
      msg_buf_o <= (i == len - 1) ? buf_num : ~buf_num;
    end
    @(posedge link_clk_i);
    byte_wr_o <= 1'b0;
    msg_end_o <= 1'b0;
    msg_buf_o <= ~buf_num;
  endtask

  task automatic send_reps(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge link_clk_i);
      bos_rep_o <= 1'b1;
      @(posedge link_clk_i);
      bos_rep_o <= 1'b0;
      repeat (3) @(posedge link_clk_i);
    end
  endtask
endmodule

// file: testbench/rx_msg_count_and_elastic_ctrl_tb.sv
// Self-checking bench for the message status and elastic control bank.
`timescale 1ns/1ps
`include "rx_msg_elastic_defines.svh"
module rx_msg_count_and_elastic_ctrl_tb;
  import rx_msg_elastic_pkg::*;
  typedef struct packed {
    logic [7:0] wr;
    logic bnd_in;
    logic clk_in;
  } row_type;
  row_type rows [5] = '{'{8'h84, 1'b0, 1'b0}, '{8'h05, 1'b1, 1'b1},
    '{8'h86, 1'b1, 1'b1}, '{8'h07, 1'b0, 1'b0}, '{8'hE1, 1'b0, 1'b1}};
  logic clk_i, sys_rst_i, link_clk, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
  logic [3:0] wb_sel_i, sig_new, sig_out;
  logic byte_wr, msg_end, msg_buf, bos_rep, eot, fast, tx_act, tx_fifo;
  logic tx_clk_oe_n, rx_clk_oe_n, slip, mframe, sig_we, sig_we_o, sync;
  logic [1:0] rx_mode;
  logic frame;
  logic [7:0] fifo_lat;
  pin_drive_type bnd;
  int errors, check_count, eot_seen, base;
  // The far side drives the boundary pin high whenever the block releases it.
  wire logic pin = bnd.oe_n ? 1'b1 : bnd.o;

  rx_msg_count_and_elastic_ctrl DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_link_clk_i(link_clk),
    .link_byte_wr_i(byte_wr), .link_msg_end_i(msg_end),
    .link_msg_buf_i(msg_buf), .link_bos_rep_i(bos_rep),
    .rx_end_of_transfer_o(eot), .backplane_fast_i(fast),
    .tx_elastic_active_o(tx_act), .tx_elastic_fifo_o(tx_fifo),
    .tx_serial_clock_oe_n_o(tx_clk_oe_n),
    .rx_serial_clock_oe_n_o(rx_clk_oe_n), .rx_elastic_mode_o(rx_mode),
    .fifo_latency_o(fifo_lat), .rx_slip_i(slip), .rx_multiframe_i(mframe),
    .sig_new_i(sig_new), .sig_array_we_i(sig_we),
    .rx_signaling_out_o(sig_out), .sig_array_we_o(sig_we_o),
    .frame_pulse_i(frame), .rx_frame_boundary_i(pin),
    .rx_frame_boundary_o(bnd), .rx_frame_sync_o(sync));

  dl_link_partner partner (.link_clk_i(link_clk), .byte_wr_o(byte_wr),
    .msg_end_o(msg_end), .msg_buf_o(msg_buf), .bos_rep_o(bos_rep));

  // ----------------------------------------------------------------------
  // Clocks, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge clk_i) if (eot === 1'b1) eot_seen++;
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Requests stay up until ack is seen; a dead slave ends on the count.
  task automatic xfer(input logic we, input logic [9:0] idx,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {20'h0, idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(q, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, slip, mframe, sig_we} = 6'h00;
    frame = 1'b0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h1;
    sig_new = 4'h3;
    fast = 1'b1;
    sys_rst_i = 1'b1;
    // The link side still takes this reset through its two-flop copy.
    tick(4);
    sys_rst_i <= 1'b0;
    rd_chk(`IDX_MSG_COUNT_PTR, 32'h0);
    rd_chk(`IDX_ELASTIC_CTRL, 32'h0);
    check(bnd.oe_n, 1'b0);
    xfer(1'b1, 10'h120, 8'hFF);
    rd_chk(10'h120, 32'h0);
    foreach (rows[i]) begin
      xfer(1'b1, `IDX_ELASTIC_CTRL, rows[i].wr);
      tick(6);
      rd_chk(`IDX_ELASTIC_CTRL, {24'h0, rows[i].wr & 8'h9F});
      check(rx_mode, rows[i].wr[1:0]);
      check(rx_clk_oe_n, rows[i].clk_in);
      check(bnd.oe_n, rows[i].bnd_in);
      check(sync, rows[i].bnd_in);
      check(tx_fifo, rows[i].wr[7]);
      check({tx_act, tx_clk_oe_n}, 2'b11);
    end
    xfer(1'b1, `IDX_ELASTIC_CTRL, 8'h80);
    fast <= 1'b0;
    tick(2);
    check({tx_fifo, tx_act, tx_clk_oe_n}, 3'b000);
    frame <= 1'b1;
    tick(1);
    check(sync, 1'b1);
    tick(1);
    check(bnd, 2'b10);
    frame <= 1'b0;
    xfer(1'b1, `IDX_FIFO_LATENCY, 8'h5A);
    check(fifo_lat, 8'h5A);
    // Signaling freeze, forced and after a slip.
    xfer(1'b1, `IDX_ELASTIC_CTRL, 8'h10);
    sig_new <= 4'hC;
    sig_we <= 1'b1;
    tick(3);
    check({sig_out, sig_we_o}, 5'h06);
    xfer(1'b1, `IDX_ELASTIC_CTRL, 8'h08);
    tick(2);
    check({sig_out, sig_we_o}, 5'h19);
    slip <= 1'b1;
    tick(1);
    slip <= 1'b0;
    sig_new <= 4'h5;
    tick(3);
    check({sig_out, sig_we_o}, 5'h18);
    mframe <= 1'b1;
    tick(1);
    mframe <= 1'b0;
    tick(3);
    check({sig_out, sig_we_o}, 5'h18);
    mframe <= 1'b1;
    tick(1);
    mframe <= 1'b0;
    tick(3);
    check({sig_out, sig_we_o}, 5'h0B);
    // Message reports include header and check bytes.
    partner.send_msg(1'b1, 9);
    tick(20);
    rd_chk(`IDX_MSG_COUNT_PTR, 32'h89);
    partner.send_msg(1'b0, 1);
    tick(20);
    rd_chk(`IDX_MSG_COUNT_PTR, 32'h01);
    // Bit-oriented repetitions against a target count.
    xfer(1'b1, `IDX_DL_CONTROL, 8'h01);
    xfer(1'b1, `IDX_MSG_COUNT_PTR, 8'h03);
    base = eot_seen;
    partner.send_reps(2);
    tick(20);
    check(eot_seen - base, 0);
    partner.send_reps(3);
    tick(20);
    check(eot_seen - base, 1);
    xfer(1'b1, `IDX_MSG_COUNT_PTR, 8'h00);
    partner.send_reps(4);
    tick(20);
    check(eot_seen - base, 1);
    sys_rst_i <= 1'b1;
    tick(10);
    sys_rst_i <= 1'b0;
    rd_chk(`IDX_FIFO_LATENCY, 32'h0);
    tally_and_finish();
  end
endmodule
